/* plm_pkg.sv */
package plm_pkg;
  // Register indices; byte address is four times the index
  localparam logic [9:0] IDX_MON = 10'h007; // Arm delay and monitor enable
  localparam logic [9:0] IDX_STS_SEL = 10'h008; // Status pin select
  localparam logic [9:0] IDX_CNT_RST = 10'h009; // Counter reset bits
  localparam logic [9:0] IDX_PRESC = 10'h00A; // Prescaler and main bypass
  localparam logic [9:0] IDX_RDIV_HI = 10'h00B; // Reference divider high
  localparam logic [9:0] IDX_RDIV_LO = 10'h00C; // Reference divider low
  localparam logic [9:0] IDX_PFD = 10'h00D; // Antibacklash and lock detect
  localparam logic [9:0] IDX_SWALLOW = 10'h00E; // Swallow count
  localparam logic [9:0] IDX_MAIN_HI = 10'h00F; // Main count high
  localparam logic [9:0] IDX_MAIN_LO = 10'h010; // Main count low
  localparam logic [9:0] IDX_STATE = 10'h01F; // Read-only live state
  localparam logic [9:0] IDX_PIN_ROLE = 10'h058; // Control pin role
  // Field positions
  localparam int ARM_LSB = 5; // 0x07[6:5]
  localparam int MON_EN_BIT = 2; // 0x07[2]
  localparam int STS_LSB = 2; // 0x08[5:2]
  localparam int SHARED_RST_BIT = 0; // 0x09[0]
  localparam int AB_RST_BIT = 1; // 0x09[1]
  localparam int BYPASS_BIT = 6; // 0x0A[6]
  localparam int PRESC_LSB = 2; // 0x0A[4:2]
  localparam int ABP_LSB = 0; // 0x0D[1:0]
  localparam int WIN_SEL_BIT = 5; // 0x0D[5]
  localparam int LD_DIS_BIT = 6; // 0x0D[6]
  localparam int ROLE_LSB = 5; // 0x58[6:5]
  // Reset values
  localparam logic [1:0] ABP_DEFAULT = 2'h0; // About 1.3 ns pulse
  localparam int ABP_DEFAULT_PS = 1300; // Width of default pulse
  localparam logic [1:0] ROLE_DEFAULT = 2'h0; // Hard reset role
  localparam logic [1:0] ROLE_RESET = 2'h0;
  localparam logic [1:0] ROLE_ALIGN = 2'h1;
  localparam logic [1:0] ROLE_PDOWN = 2'h3;
  // Prescaler codes
  localparam logic [2:0] PRESC_FD1 = 3'h0;
  localparam logic [2:0] PRESC_FD2 = 3'h1;
  localparam logic [2:0] PRESC_DM2 = 3'h2;
  localparam logic [2:0] PRESC_DM4 = 3'h3;
  localparam logic [2:0] PRESC_DM8 = 3'h4;
  localparam logic [2:0] PRESC_DM16 = 3'h5;
  localparam logic [2:0] PRESC_DM32 = 3'h6;
  localparam logic [2:0] PRESC_FD3 = 3'h7;
  // Status select codes
  localparam logic [3:0] STS_ZERO = 4'h0;
  localparam logic [3:0] STS_DLD_HI = 4'h1;
  localparam logic [3:0] STS_DLD_LO = 4'h2;
  localparam logic [3:0] STS_RDIV = 4'h3;
  localparam logic [3:0] STS_FDIV = 4'h4;
  localparam logic [3:0] STS_ALD_N = 4'h5;
  localparam logic [3:0] STS_REFERENCE_LOST_FLAG_HI = 4'hA;
  localparam logic [3:0] STS_ALD_P = 4'hC;
  localparam logic [3:0] STS_UNLK_HI = 4'hD;
  localparam logic [3:0] STS_UNLK_LO = 4'hE;
  localparam logic [3:0] STS_REFERENCE_LOST_FLAG_LO = 4'hF;
  // Arm delays in phase detector cycles per code
  localparam logic [4:0] ARM_CYC0 = 5'h03;
  localparam logic [4:0] ARM_CYC1 = 5'h06;
  localparam logic [4:0] ARM_CYC2 = 5'h0C;
  localparam logic [4:0] ARM_CYC3 = 5'h18;
  // Lock windows, printed times and derived cycles at 100 MHz
  localparam int CLK_PERIOD_PS = 10000;
  localparam int WIDE_ON_PS = 9500;
  localparam int WIDE_OFF_PS = 15000;
  localparam int NARROW_ON_PS = 3500;
  localparam int NARROW_OFF_PS = 7000;
  localparam int WIDE_ON_CYC = (WIDE_ON_PS / CLK_PERIOD_PS < 1) ? 1 : WIDE_ON_PS / CLK_PERIOD_PS;
  localparam int WIDE_OFF_CYC = (WIDE_OFF_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int NARROW_ON_CYC = (NARROW_ON_PS / CLK_PERIOD_PS < 1) ? 1 : NARROW_ON_PS / CLK_PERIOD_PS;
  localparam int NARROW_OFF_CYC = (NARROW_OFF_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // Bus carriers
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } plm_apb_req_t;
  typedef struct packed {
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
  } plm_apb_rsp_t;
  typedef struct packed {
    logic level;
    logic oe_n;
  } plm_pin_t;
endpackage

/* plm_core.sv */
`timescale 1ns/10ps
// What this block does
// - main bypass divides by one, fixed mode only
// - main count legal 3 to 8191, default zero
// - fixed mode ignores swallow count
// - own A/B reset, shared reset R/A/B
// - dual modulus divides by P*B plus A
// - fixed mode divides by P*B
// - two-bit antibacklash select, default 1.3 ns
// - four-bit select drives status pin
// - wide window locks 9.5 ns, unlocks 15 ns
// - narrow window locks 3.5 ns, unlocks 7 ns
// - disable bit stops lock flag generation
// - lock flag may survive reference loss
// - codes 1100/0101 give open-drain analog lock
// - codes 1010/1111 give reference-lost flag
// - codes 1101/1110 give unlock OR lost
// - loss count advances on VCO edges, arm count on reference pulses
// - monitor arms after 3 to 24 locked cycles
// - armed loss sets flag, tristates pump
// - enable low clears flag, high re-arms
// - two-bit role select, pin low resets
// - roles 00 reset, 01 align, 11 power-down
// - 14-bit reference divider, zero divides one
// - prescaler codes select fixed or dual modulus
module plm_core (
  input wire logic clk, // 100 MHz clock
  input wire logic sys_rst, // Synchronous reset, high
  input wire plm_pkg::plm_apb_req_t apb_req, // APB request
  output plm_pkg::plm_apb_rsp_t apb_rsp, // APB answer
  input wire logic reference_input, // Reference clock pin
  input wire logic vco_feedback_input, // VCO feedback pin
  input wire logic control_pin, // Multipurpose control pin
  output plm_pkg::plm_pin_t status_pin, // Status pin drive
  output logic [1:0] abp_width_sel, // Antibacklash width code
  output logic cp_tristate, // Charge pump tristate
  output logic ref_div_pulse, // Reference divider output
  output logic fb_div_pulse, // Feedback divider output
  output logic digital_lock_flag, // Lock flag
  output logic reference_lost_flag, // Loss flag
  output logic hard_reset_n, // Hard reset from pin
  output logic output_align_n, // Output sync from pin
  output logic full_power_down_n // Power-down from pin
);
  import plm_pkg::*;

  // Pin synchronisers and edge history
  logic [2:0] ref_sh_reg; // Meta, sync, previous
  logic [2:0] vco_sh_reg; // Meta, sync, previous
  logic [1:0] pin_sh_reg; // Meta, sync

  // Configuration registers
  logic [1:0] arm_code_reg; // Arm delay code
  logic mon_en_reg; // Loss monitor enable
  logic [3:0] sts_sel_reg; // Status pin select
  logic shared_rst_reg; // R/A/B reset
  logic ab_rst_reg; // A/B reset
  logic bypass_reg; // Main counter bypass
  logic [2:0] presc_reg; // Prescaler mode
  logic [13:0] rdiv_reg; // Reference divide value
  logic [1:0] abp_reg; // Antibacklash select
  logic win_sel_reg; // Narrow window select
  logic ld_dis_reg; // Lock detect disable
  logic [5:0] adiv_reg; // Swallow count
  logic [12:0] bdiv_reg; // Main count
  logic [1:0] role_reg; // Control pin role

  // Edges seen on the clock domain
  wire ref_edge = ref_sh_reg[1] & ~ref_sh_reg[2];
  wire vco_edge = vco_sh_reg[1] & ~vco_sh_reg[2];
  wire pin_low = ~pin_sh_reg[1];
  wire cfg_rst = sys_rst | (pin_low & (role_reg == ROLE_RESET));

  // Bus decode
  wire [9:0] idx = apb_req.paddr[11:2];
  wire setup = apb_req.psel & ~apb_req.penable;
  wire wr_en = apb_req.psel & apb_req.penable & apb_req.pwrite & apb_rsp.pready & ~apb_rsp.pslverr;
  wire [7:0] wd = apb_req.pwdata[7:0];
  logic [7:0] rd_data; // Selected read value
  logic hit; // Index is mapped

  // Synchronise the three pins
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ref_sh_reg <= 3'h0;
      vco_sh_reg <= 3'h0;
      pin_sh_reg <= 2'h0;
    end else begin
      ref_sh_reg <= {ref_sh_reg[1:0], reference_input};
      vco_sh_reg <= {vco_sh_reg[1:0], vco_feedback_input};
      pin_sh_reg <= {pin_sh_reg[0], control_pin};
    end
  end

  // Register writes; pin reset role reloads defaults
  always_ff @(posedge clk) begin
    if (cfg_rst) begin
      arm_code_reg <= 2'h0;
      mon_en_reg <= 1'b0;
      sts_sel_reg <= STS_ZERO;
      shared_rst_reg <= 1'b0;
      ab_rst_reg <= 1'b0;
      bypass_reg <= 1'b0;
      presc_reg <= PRESC_FD1;
      rdiv_reg <= 14'h0000;
      abp_reg <= ABP_DEFAULT;
      win_sel_reg <= 1'b0;
      ld_dis_reg <= 1'b0;
      adiv_reg <= 6'h00;
      bdiv_reg <= 13'h0000;
      role_reg <= ROLE_DEFAULT;
    end else if (wr_en) begin
      case (idx)
        IDX_MON: begin
          arm_code_reg <= wd[ARM_LSB+:2];
          mon_en_reg <= wd[MON_EN_BIT];
        end
        IDX_STS_SEL: sts_sel_reg <= wd[STS_LSB+:4];
        IDX_CNT_RST: begin
          shared_rst_reg <= wd[SHARED_RST_BIT];
          ab_rst_reg <= wd[AB_RST_BIT];
        end
        IDX_PRESC: begin
          bypass_reg <= wd[BYPASS_BIT];
          presc_reg <= wd[PRESC_LSB+:3];
        end
        IDX_RDIV_HI: rdiv_reg[13:8] <= wd[5:0];
        IDX_RDIV_LO: rdiv_reg[7:0] <= wd;
        IDX_PFD: begin
          abp_reg <= wd[ABP_LSB+:2];
          win_sel_reg <= wd[WIN_SEL_BIT];
          ld_dis_reg <= wd[LD_DIS_BIT];
        end
        IDX_SWALLOW: adiv_reg <= wd[5:0];
        IDX_MAIN_HI: bdiv_reg[12:8] <= wd[4:0];
        IDX_MAIN_LO: bdiv_reg[7:0] <= wd;
        IDX_PIN_ROLE: role_reg <= wd[ROLE_LSB+:2];
        default: ;
      endcase
    end
  end

  // Read mux
  logic armed_reg; // Loss monitor armed
  always_comb begin
    hit = 1'b1;
    rd_data = 8'h00;
    case (idx)
      IDX_MON: rd_data = {1'b0, arm_code_reg, 2'h0, mon_en_reg, 2'h0};
      IDX_STS_SEL: rd_data = {2'h0, sts_sel_reg, 2'h0};
      IDX_CNT_RST: rd_data = {6'h00, ab_rst_reg, shared_rst_reg};
      IDX_PRESC: rd_data = {1'b0, bypass_reg, 1'b0, presc_reg, 2'h0};
      IDX_RDIV_HI: rd_data = {2'h0, rdiv_reg[13:8]};
      IDX_RDIV_LO: rd_data = rdiv_reg[7:0];
      IDX_PFD: rd_data = {1'b0, ld_dis_reg, win_sel_reg, 3'h0, abp_reg};
      IDX_SWALLOW: rd_data = {2'h0, adiv_reg};
      IDX_MAIN_HI: rd_data = {3'h0, bdiv_reg[12:8]};
      IDX_MAIN_LO: rd_data = bdiv_reg[7:0];
      IDX_STATE: rd_data = {5'h00, armed_reg, reference_lost_flag, digital_lock_flag};
      IDX_PIN_ROLE: rd_data = {1'b0, role_reg, 5'h00};
      default: hit = 1'b0;
    endcase
  end

  // Zero-wait answer prepared in the setup cycle
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      apb_rsp <= '0;
    end else if (setup) begin
      apb_rsp.pready <= 1'b1;
      apb_rsp.pslverr <= ~hit | (apb_req.paddr[1:0] != 2'h0);
      apb_rsp.prdata <= {24'h000000, rd_data};
    end else begin
      apb_rsp <= '0;
    end
  end

  // Feedback division ratio
  logic [5:0] p_val; // Prescaler value P
  wire dm_mode = (presc_reg >= PRESC_DM2) && (presc_reg <= PRESC_DM32);
  always_comb begin
    case (presc_reg)
      PRESC_FD1: p_val = 6'h01;
      PRESC_FD2: p_val = 6'h02;
      PRESC_FD3: p_val = 6'h03;
      PRESC_DM2: p_val = 6'h02;
      PRESC_DM4: p_val = 6'h04;
      PRESC_DM8: p_val = 6'h08;
      PRESC_DM16: p_val = 6'h10;
      PRESC_DM32: p_val = 6'h20;
      default: p_val = 6'h01;
    endcase
  end
  wire [12:0] b_eff = (!dm_mode && bypass_reg) ? 13'h0001 : bdiv_reg;
  wire [19:0] pb_prod = 20'(p_val) * 20'(b_eff); // Widen before multiply, product needs 18 bits
  wire [19:0] n_total = dm_mode ? 20'(pb_prod + {14'h0000, adiv_reg}) : pb_prod;
  wire [19:0] n_eff = (n_total == 20'h00000) ? 20'h00001 : n_total;
  wire [13:0] r_eff = (rdiv_reg == 14'h0000) ? 14'h0001 : rdiv_reg;

  // Reference and feedback counters
  logic [13:0] rcnt_reg; // Reference count
  logic [19:0] fcnt_reg; // Feedback count
  wire r_rst = cfg_rst | shared_rst_reg;
  wire ab_rst = cfg_rst | shared_rst_reg | ab_rst_reg;
  wire r_wrap = ref_edge && (rcnt_reg >= 14'(r_eff - 14'h0001));
  wire f_wrap = vco_edge && (fcnt_reg >= 20'(n_eff - 20'h00001));
  always_ff @(posedge clk) begin
    if (r_rst) begin
      rcnt_reg <= 14'h0000;
      ref_div_pulse <= 1'b0;
    end else begin
      rcnt_reg <= r_wrap ? 14'h0000 : (ref_edge ? 14'(rcnt_reg + 14'h0001) : rcnt_reg);
      ref_div_pulse <= r_wrap;
    end
  end
  always_ff @(posedge clk) begin
    if (ab_rst) begin
      fcnt_reg <= 20'h00000;
      fb_div_pulse <= 1'b0;
    end else begin
      fcnt_reg <= f_wrap ? 20'h00000 : (vco_edge ? 20'(fcnt_reg + 20'h00001) : fcnt_reg);
      fb_div_pulse <= f_wrap;
    end
  end

  // Digital lock detect on divider pulse coincidence
  logic pend_ref_reg; // Reference edge awaits partner
  logic pend_fb_reg; // Feedback edge awaits partner
  logic [4:0] sep_reg; // Cycles since unmatched edge
  wire [4:0] on_cyc = win_sel_reg ? 5'(NARROW_ON_CYC) : 5'(WIDE_ON_CYC);
  wire [4:0] off_cyc = win_sel_reg ? 5'(NARROW_OFF_CYC) : 5'(WIDE_OFF_CYC);
  wire pair_ref = ref_div_pulse & pend_fb_reg; // Reference closes a pair
  wire pair_fb = fb_div_pulse & pend_ref_reg; // Feedback closes a pair
  wire both = ref_div_pulse & fb_div_pulse;
  wire pair = pair_ref | pair_fb;
  wire lone = (ref_div_pulse & pend_ref_reg) | (fb_div_pulse & pend_fb_reg);
  always_ff @(posedge clk) begin
    if (cfg_rst || ld_dis_reg) begin
      digital_lock_flag <= 1'b0;
      pend_ref_reg <= 1'b0;
      pend_fb_reg <= 1'b0;
      sep_reg <= 5'h00;
    end else if (both) begin
      digital_lock_flag <= 1'b1;
      pend_ref_reg <= 1'b0;
      pend_fb_reg <= 1'b0;
      sep_reg <= 5'h00;
    end else if (pair) begin
      if (sep_reg < on_cyc) begin
        digital_lock_flag <= 1'b1;
      end else if (sep_reg >= off_cyc) begin
        digital_lock_flag <= 1'b0;
      end
      pend_ref_reg <= 1'b0;
      pend_fb_reg <= 1'b0;
      sep_reg <= 5'h00;
    end else if (lone) begin
      digital_lock_flag <= 1'b0; // Partner edge never came
      sep_reg <= 5'h00;
    end else if (ref_div_pulse || fb_div_pulse) begin
      pend_ref_reg <= ref_div_pulse;
      pend_fb_reg <= fb_div_pulse;
      sep_reg <= 5'h00;
    end else if (pend_ref_reg || pend_fb_reg) begin
      if (sep_reg >= off_cyc - 5'h01) begin
        digital_lock_flag <= 1'b0;
      end
      if (sep_reg < off_cyc) begin
        sep_reg <= 5'(sep_reg + 5'h01);
      end
    end
  end
  wire analog_lock_indicator = ~(pend_ref_reg | pend_fb_reg); // Analog lock, false while apart

  // Arm delay counted in phase detector cycles
  logic [4:0] arm_cnt_reg; // Locked cycles seen
  logic [4:0] arm_target; // Cycles needed
  logic [20:0] since_ref_reg; // VCO edges since reference pulse
  always_comb begin
    case (arm_code_reg)
      2'h0: arm_target = ARM_CYC0;
      2'h1: arm_target = ARM_CYC1;
      2'h2: arm_target = ARM_CYC2;
      default: arm_target = ARM_CYC3;
    endcase
  end
  wire loss_ev = vco_edge && (since_ref_reg >= {n_eff, 1'b0});
  always_ff @(posedge clk) begin
    if (cfg_rst || !mon_en_reg || !digital_lock_flag) begin
      arm_cnt_reg <= 5'h00;
    end else if (ref_div_pulse && arm_cnt_reg < arm_target) begin
      arm_cnt_reg <= 5'(arm_cnt_reg + 5'h01);
    end
  end
  always_ff @(posedge clk) begin
    if (cfg_rst || !mon_en_reg) begin
      armed_reg <= 1'b0;
      reference_lost_flag <= 1'b0;
      cp_tristate <= 1'b0;
      since_ref_reg <= 21'h000000;
    end else begin
      if (arm_cnt_reg >= arm_target && digital_lock_flag) begin
        armed_reg <= 1'b1;
      end
      if (ref_div_pulse) begin
        since_ref_reg <= 21'h000000;
      end else if (vco_edge && !loss_ev) begin
        since_ref_reg <= 21'(since_ref_reg + 21'h000001);
      end
      if (armed_reg && loss_ev) begin
        reference_lost_flag <= 1'b1;
        cp_tristate <= 1'b1;
      end
    end
  end

  // Status pin multiplexer
  logic st_level; // Pin level
  logic st_oe_n; // Pin released when high
  wire unlock = ~digital_lock_flag | reference_lost_flag;
  always_comb begin
    st_oe_n = 1'b0;
    case (sts_sel_reg)
      STS_DLD_HI: st_level = digital_lock_flag;
      STS_DLD_LO: st_level = ~digital_lock_flag;
      STS_RDIV: st_level = ref_div_pulse;
      STS_FDIV: st_level = fb_div_pulse;
      STS_ALD_P: begin
        st_level = 1'b1;
        st_oe_n = ~analog_lock_indicator;
      end
      STS_ALD_N: begin
        st_level = 1'b0;
        st_oe_n = ~analog_lock_indicator;
      end
      STS_REFERENCE_LOST_FLAG_HI: st_level = reference_lost_flag;
      STS_REFERENCE_LOST_FLAG_LO: st_level = ~reference_lost_flag;
      STS_UNLK_HI: st_level = unlock;
      STS_UNLK_LO: st_level = ~unlock;
      default: st_level = 1'b0;
    endcase
  end

  // Registered pin-facing outputs
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      status_pin <= '0;
      abp_width_sel <= ABP_DEFAULT;
      hard_reset_n <= 1'b0;
      output_align_n <= 1'b1;
      full_power_down_n <= 1'b1;
    end else begin
      status_pin.level <= st_level;
      status_pin.oe_n <= st_oe_n;
      abp_width_sel <= abp_reg;
      hard_reset_n <= ~(pin_low && role_reg == ROLE_RESET);
      output_align_n <= ~(pin_low && role_reg == ROLE_ALIGN);
      full_power_down_n <= ~(pin_low && role_reg == ROLE_PDOWN);
    end
  end

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence s_lost;
    armed_reg && mon_en_reg && loss_ev && !cfg_rst;
  endsequence
  sequence s_flagged;
    reference_lost_flag && cp_tristate;
  endsequence
  AST_BYPASS_FD: assert property (!dm_mode && bypass_reg |-> n_total == 20'(p_val))
    else $error("bypass does not divide main count by one");
  AST_FD_RATIO: assert property (!dm_mode && !bypass_reg |-> n_total == 20'(p_val) * 20'(bdiv_reg))
    else $error("fixed mode ratio wrong");
  AST_DM_RATIO: assert property (dm_mode |-> n_total == 20'(p_val) * 20'(bdiv_reg) + 20'(adiv_reg))
    else $error("dual modulus ratio wrong");
  AST_FB_WRAP: assert property (f_wrap && !ab_rst |=> fb_div_pulse && fcnt_reg == 20'h00000)
    else $error("feedback divider did not wrap");
  AST_LD_OFF: assert property (ld_dis_reg |=> !digital_lock_flag)
    else $error("lock flag active while disabled");
  AST_LOCK_BOTH: assert property (both && !ld_dis_reg && !cfg_rst |=> digital_lock_flag)
    else $error("coincident edges did not lock");
  AST_REFERENCE_LOST_FLAG_SET: assert property (s_lost |=> s_flagged)
    else $error("loss not flagged");
  AST_RECOVER: assert property (!mon_en_reg |=> !reference_lost_flag && !cp_tristate && !armed_reg)
    else $error("monitor disable did not clear loss");
  AST_ARM_NEEDS_LOCK: assert property ($rose(armed_reg) |-> $past(digital_lock_flag))
    else $error("monitor armed without lock");
  AST_STS_REFERENCE_LOST_FLAG: assert property (sts_sel_reg == STS_REFERENCE_LOST_FLAG_LO |=> status_pin.level == !$past(reference_lost_flag))
    else $error("status pin does not show inverted loss flag");
  AST_REF_DIV1: assert property (rdiv_reg == 14'h0000 && ref_edge && !r_rst |=> ref_div_pulse)
    else $error("zero reference divide is not one");
endmodule

/* plm_clk_src.sv */
`timescale 1ns/10ps
// Reference source and VCO, toggling on one shared count so their edges line up
module plm_clk_src (
  input wire logic clk, // Bench clock
  input wire logic vco_on, // VCO running
  input wire logic ref_on, // Reference running
  input wire logic [3:0] half, // Half period in clk cycles
  output logic reference_input, // Reference clock
  output logic vco_feedback_input // VCO clock
);
  logic [3:0] cnt_reg; // Half-period count
  initial begin
    cnt_reg = 4'h0;
    reference_input = 1'b0;
    vco_feedback_input = 1'b0;
  end
  // A stopped clock rests low; a restarted reference follows the VCO phase
  always @(posedge clk) begin
    cnt_reg <= (cnt_reg >= half - 4'h1) ? 4'h0 : cnt_reg + 4'h1;
    if (cnt_reg >= half - 4'h1) begin
      vco_feedback_input <= vco_on ? ~vco_feedback_input : 1'b0;
      reference_input <= vco_on & ref_on & ~vco_feedback_input;
    end
  end
endmodule

/* pll_counter_lock_monitor_bench.sv */
`timescale 1ns/10ps
module pll_counter_lock_monitor_bench;
  import plm_pkg::*;
  // Divider case: settings beside expected feedback and reference divisions
  typedef struct packed {
    logic [2:0] presc; // Prescaler code
    logic byp; // Main bypass
    logic [5:0] swl; // Swallow count
    logic [12:0] main; // Main count
    logic [7:0] r; // Reference divide
    logic [9:0] n; // Expected feedback division
    logic [9:0] rp; // Expected reference division
  } plm_row_t;
  logic clk, sys_rst, control_pin, vco_on, ref_on; // Bench drives
  logic reference_input, vco_feedback_input; // Partner clocks
  plm_apb_req_t apb_req; // Bus request
  plm_apb_rsp_t apb_rsp; // Bus answer
  plm_pin_t status_pin; // Status pin
  logic [1:0] abp_width_sel; // Antibacklash code
  logic cp_tristate, ref_div_pulse, fb_div_pulse, digital_lock_flag, reference_lost_flag;
  logic hard_reset_n, output_align_n, full_power_down_n; // Pin roles
  logic [31:0] rd_val; // Last read data
  logic err_val; // Last error flag
  int fail_count, num_checks, p; // Counters and measured period
  plm_row_t rows [11] = '{
    '{PRESC_FD1, 1'b1, 6'h00, 13'h0000, 8'h00, 10'h001, 10'h001},
    '{PRESC_FD2, 1'b1, 6'h00, 13'h0000, 8'h01, 10'h002, 10'h001},
    '{PRESC_FD3, 1'b1, 6'h00, 13'h0000, 8'h03, 10'h003, 10'h003},
    '{PRESC_FD2, 1'b0, 6'h05, 13'h0003, 8'h02, 10'h006, 10'h002},
    '{PRESC_DM2, 1'b1, 6'h00, 13'h0003, 8'h01, 10'h006, 10'h001},
    '{PRESC_DM2, 1'b0, 6'h01, 13'h0003, 8'h01, 10'h007, 10'h001},
    '{PRESC_DM4, 1'b0, 6'h01, 13'h0003, 8'h01, 10'h00D, 10'h001},
    '{PRESC_DM8, 1'b0, 6'h00, 13'h0003, 8'h01, 10'h018, 10'h001},
    '{PRESC_DM16, 1'b0, 6'h02, 13'h0003, 8'h01, 10'h032, 10'h001},
    '{PRESC_DM32, 1'b0, 6'h01, 13'h0003, 8'h01, 10'h061, 10'h001},
    '{PRESC_FD1, 1'b0, 6'h09, 13'h0004, 8'h01, 10'h004, 10'h001}};
  // Status code with pin level and drive, no lock, no loss, nothing pending
  logic [5:0] sts [8] = '{{STS_ZERO, 2'b00}, {STS_DLD_LO, 2'b10}, {STS_REFERENCE_LOST_FLAG_HI, 2'b00}, {STS_REFERENCE_LOST_FLAG_LO, 2'b10},
    {STS_UNLK_HI, 2'b10}, {STS_UNLK_LO, 2'b00}, {STS_ALD_N, 2'b00}, {STS_ALD_P, 2'b10}};
  plm_core plm_core_inst (.clk, .sys_rst, .apb_req, .apb_rsp, .reference_input, .vco_feedback_input,
    .control_pin, .status_pin, .abp_width_sel, .cp_tristate, .ref_div_pulse, .fb_div_pulse,
    .digital_lock_flag, .reference_lost_flag, .hard_reset_n, .output_align_n, .full_power_down_n);
  plm_clk_src plm_clk_src_inst (.clk, .vco_on, .ref_on, .half(4'h4), .reference_input, .vco_feedback_input);
  // Clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic [9:0] idx, input logic wr, input logic [7:0] wd);
    int k;
    @(posedge clk);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: {idx, 2'b00}, pwdata: {24'h0, wd}};
    @(posedge clk);
    apb_req.penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (apb_rsp.pready !== 1'b1 && k < 20);
    if (apb_rsp.pready !== 1'b1) fail_count++;
    rd_val = apb_rsp.prdata;
    err_val = apb_rsp.pslverr;
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
  endtask
  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    apb(idx, 1'b1, d);
  endtask
  task automatic rchk(input logic [9:0] idx, input logic [31:0] exp, input logic exp_err);
    apb(idx, 1'b0, 8'h00);
    chk(rd_val, exp);
    chk({31'h0, err_val}, {31'h0, exp_err});
  endtask
  // Let edges pass, then sample settled outputs
  task automatic waitc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Interval between the second and third divider pulse
  task automatic per(input logic fb, output int pv);
    int k;
    for (int s = 0; s < 3; s++) begin
      k = 0;
      do begin
        @(posedge clk);
        #1;
        k++;
      end while ((fb ? fb_div_pulse : ref_div_pulse) !== 1'b1 && k < 1000);
      pv = k;
    end
  endtask
  task automatic cfg(input plm_row_t rw);
    wr(IDX_PRESC, {1'b0, rw.byp, 1'b0, rw.presc, 2'b00});
    wr(IDX_SWALLOW, {2'b00, rw.swl});
    wr(IDX_MAIN_HI, {3'b000, rw.main[12:8]});
    wr(IDX_MAIN_LO, rw.main[7:0]);
    wr(IDX_RDIV_LO, rw.r);
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Hang guard
  initial begin
    int cycles;
    cycles = 0;
    while (cycles < 40000) begin
      @(posedge clk);
      cycles++;
    end
    fail_count++;
    finish_test;
  end
  // Main sequence
  initial begin
    fail_count = 0;
    num_checks = 0;
    sys_rst = 1'b1;
    control_pin = 1'b1;
    vco_on = 1'b0;
    ref_on = 1'b0;
    apb_req = '0;
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    waitc(1);
    chk(abp_width_sel, 2'h0);
    rchk(IDX_MAIN_LO, 32'h0, 1'b0);
    rchk(IDX_PFD, 32'h0, 1'b0);
    rchk(10'h020, 32'h0, 1'b1);
    wr(IDX_PFD, 8'h02);
    waitc(2);
    chk(abp_width_sel, 2'h2);
    wr(IDX_PFD, 8'h00);
    foreach (sts[i]) begin
      wr(IDX_STS_SEL, {2'b00, sts[i][5:2], 2'b00});
      waitc(3);
      chk(status_pin, sts[i][1:0]);
    end
    vco_on <= 1'b1;
    ref_on <= 1'b1;
    foreach (rows[i]) begin
      cfg(rows[i]);
      per(1'b1, p);
      chk(32'(p), 32'(8 * rows[i].n));
      per(1'b0, p);
      chk(32'(p), 32'(8 * rows[i].rp));
    end
    wr(IDX_CNT_RST, 8'h02);
    p = 0;
    repeat (200) begin
      @(posedge clk);
      #1;
      if (fb_div_pulse !== 1'b0) p++;
    end
    chk(32'(p), 32'h0);
    wr(IDX_CNT_RST, 8'h01);
    p = 0;
    repeat (100) begin
      @(posedge clk);
      #1;
      if (ref_div_pulse !== 1'b0 || fb_div_pulse !== 1'b0) p++;
    end
    chk(32'(p), 32'h0);
    wr(IDX_CNT_RST, 8'h00);
    cfg(rows[0]);
    waitc(40);
    chk(digital_lock_flag, 1'b1);
    wr(IDX_PFD, 8'h20);
    waitc(40);
    chk(digital_lock_flag, 1'b1);
    wr(IDX_PFD, 8'h40);
    waitc(20);
    chk(digital_lock_flag, 1'b0);
    wr(IDX_PFD, 8'h00);
    wr(IDX_MON, 8'h64);
    waitc(100);
    ref_on <= 1'b0;
    waitc(150);
    chk(reference_lost_flag, 1'b0);
    ref_on <= 1'b1;
    waitc(300);
    rchk(IDX_STATE, 32'h5, 1'b0);
    ref_on <= 1'b0;
    waitc(60);
    chk({reference_lost_flag, cp_tristate}, 2'b11);
    wr(IDX_STS_SEL, {2'b00, STS_REFERENCE_LOST_FLAG_HI, 2'b00});
    waitc(3);
    chk(status_pin, 2'b10);
    wr(IDX_MON, 8'h60);
    waitc(2);
    chk({reference_lost_flag, cp_tristate}, 2'b00);
    wr(IDX_MON, 8'h64);
    ref_on <= 1'b1;
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    waitc(1);
    chk({digital_lock_flag, reference_lost_flag, cp_tristate}, 3'b000);
    rchk(IDX_MON, 32'h0, 1'b0);
    wr(IDX_PFD, 8'h01);
    control_pin <= 1'b0;
    waitc(5);
    chk({hard_reset_n, abp_width_sel}, 3'b000);
    control_pin <= 1'b1;
    waitc(5);
    rchk(IDX_PFD, 32'h0, 1'b0);
    wr(IDX_PIN_ROLE, {1'b0, ROLE_ALIGN, 5'h00});
    control_pin <= 1'b0;
    waitc(5);
    chk({hard_reset_n, output_align_n, full_power_down_n}, 3'b101);
    control_pin <= 1'b1;
    wr(IDX_PIN_ROLE, {1'b0, ROLE_PDOWN, 5'h00});
    control_pin <= 1'b0;
    waitc(5);
    chk({hard_reset_n, output_align_n, full_power_down_n}, 3'b110);
    control_pin <= 1'b1;
    waitc(5);
    finish_test;
  end
endmodule
